// ==== design/drs_debug_run_status.sv ====
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module drs_debug_run_status
  import drs_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // debug unit signals, same clock
  input wire logic comp_a_match_in,
  input wire logic comp_b_match_in,
  input wire logic trigger_in,
  input wire logic capture_word_in,
  input wire logic fifo_read_in,
  // run state towards the capture logic
  output logic capture_store_out,
  output logic armed_out,
  // AXI4-Lite write channels
  input wire logic [DRS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [DRS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // ==========================================================
  // helpers
  function automatic logic is_mapped(input logic [DRS_ADDR_W-1:0] addr);
    is_mapped = (addr == DRS_STATUS_OFS) || (addr == DRS_CONTROL_OFS);
  endfunction

  // ==========================================================
  // state
  drs_ctrl_t ctrl;
  drs_status_t status;
  logic storing;
  logic aw_held;
  logic w_held;
  logic [DRS_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // status fields, one register each so no two processes share a variable
  logic comparator_a_hit_flag;
  logic comparator_b_hit_flag;
  logic armed_status_flag;
  logic [3:0] fifo_valid_count;
  localparam drs_status_t STATUS_RST = drs_status_t'(DRS_STATUS_RESET);

  // ==========================================================
  // write channel sequencing
  logic take_aw;
  logic take_w;
  logic have_aw;
  logic have_w;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic [DRS_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  always_comb begin
    take_aw = s_axi_awvalid_in && s_axi_awready_out;
    take_w = s_axi_wvalid_in && s_axi_wready_out;
    have_aw = aw_held || take_aw;
    have_w = w_held || take_w;
    do_write = have_aw && have_w && !s_axi_bvalid_out;
    next_aw_held = have_aw && !do_write;
    next_w_held = have_w && !do_write;
    next_bvalid = do_write || (s_axi_bvalid_out && !s_axi_bready_in);
    wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
    wr_data = w_held ? w_data : s_axi_wdata_in;
    wr_strb = w_held ? w_strb : s_axi_wstrb_in;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      // a parked beat or a pending answer closes the channel, so no beat is lost
      s_axi_awready_out <= !next_aw_held && !next_bvalid;
      s_axi_wready_out <= !next_w_held && !next_bvalid;
      s_axi_bvalid_out <= next_bvalid;
    end
  end

  // address and data parked here when the two channels arrive apart
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (take_aw) begin
        aw_addr <= s_axi_awaddr_in;
      end
      if (take_w) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      s_axi_bresp_out <= DRS_RESP_OKAY;
    end else if (do_write) begin
      // status writes are accepted with OKAY but discarded
      s_axi_bresp_out <= is_mapped(wr_addr) ? DRS_RESP_OKAY : DRS_RESP_SLVERR;
    end
  end

  // ==========================================================
  // run control
  logic ctrl_write;
  drs_ctrl_t wr_ctrl;
  logic armed_now;
  logic run_start;
  logic fifo_full;
  logic hw_end;
  logic store_word;

  always_comb begin
    ctrl_write = do_write && (wr_addr == DRS_CONTROL_OFS) && wr_strb[0];
    wr_ctrl.debug_module_enable = wr_data[DRS_CTL_ENABLE_BIT];
    wr_ctrl.arm = wr_data[DRS_CTL_ARM_BIT];
    wr_ctrl.begin_trace = wr_data[DRS_CTL_BEGIN_BIT];
    armed_now = ctrl.arm && ctrl.debug_module_enable;
    // rewriting control while armed is not a new start, so the run keeps its flags
    run_start = ctrl_write && wr_ctrl.arm && wr_ctrl.debug_module_enable && !armed_now;
    // a full FIFO ends a begin trace and blocks further stores
    fifo_full = (fifo_valid_count == DRS_FIFO_DEPTH);
    hw_end = armed_now && (ctrl.begin_trace ? fifo_full : trigger_in);
    // end trace keeps the newest words, so the count just saturates
    store_word = armed_now && capture_word_in && !fifo_full
        && (storing || !ctrl.begin_trace);
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl.debug_module_enable <= DRS_CONTROL_RESET[DRS_CTL_ENABLE_BIT];
      ctrl.arm <= DRS_CONTROL_RESET[DRS_CTL_ARM_BIT];
      ctrl.begin_trace <= DRS_CONTROL_RESET[DRS_CTL_BEGIN_BIT];
    end else if (ctrl_write) begin
      // writing 0 to arm or enable ends the run at once
      ctrl <= wr_ctrl;
    end else if (hw_end) begin
      ctrl.arm <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      storing <= 1'b0;
    end else if (run_start || !armed_now) begin
      storing <= 1'b0;
    end else if (ctrl.begin_trace && trigger_in) begin
      storing <= 1'b1;
    end
  end

  // ==========================================================
  // status flags
  always_comb begin
    status.comparator_a_hit_flag = comparator_a_hit_flag;
    status.comparator_b_hit_flag = comparator_b_hit_flag;
    status.armed_status_flag = armed_status_flag;
    // bit 4 has no function and is tied low
    status.reserved = 1'b0;
    status.fifo_valid_count = fifo_valid_count;
  end

  // hits count only while armed and a start needs a disarmed unit, so the two never collide
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      comparator_a_hit_flag <= STATUS_RST.comparator_a_hit_flag;
    end else if (run_start) begin
      comparator_a_hit_flag <= 1'b0;
    end else if (armed_now && comp_a_match_in) begin
      comparator_a_hit_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      comparator_b_hit_flag <= STATUS_RST.comparator_b_hit_flag;
    end else if (run_start) begin
      comparator_b_hit_flag <= 1'b0;
    end else if (armed_now && comp_b_match_in) begin
      comparator_b_hit_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      fifo_valid_count <= STATUS_RST.fifo_valid_count;
    end else if (run_start) begin
      fifo_valid_count <= 4'h0;
    end else if (store_word) begin
      // host reads never touch the count; fifo_read_in is ignored here
      fifo_valid_count <= fifo_valid_count + 4'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      armed_status_flag <= STATUS_RST.armed_status_flag;
    end else begin
      // one cycle behind the control bit, matching the other registered views
      armed_status_flag <= ctrl.debug_module_enable && ctrl.arm;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      armed_out <= 1'b0;
      capture_store_out <= 1'b0;
    end else begin
      armed_out <= armed_now;
      capture_store_out <= armed_now && (storing || !ctrl.begin_trace);
    end
  end

  // ==========================================================
  // read channel
  logic take_ar;
  logic next_rvalid;

  always_comb begin
    take_ar = s_axi_arvalid_in && s_axi_arready_out;
    next_rvalid = take_ar || (s_axi_rvalid_out && !s_axi_rready_in);
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
    end else begin
      // one read in flight: the address is refused until the data is taken
      s_axi_arready_out <= !next_rvalid;
      s_axi_rvalid_out <= next_rvalid;
    end
  end

  // data is latched at the address handshake, so it stands still while rvalid waits
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= DRS_RESP_OKAY;
    end else if (take_ar) begin
      s_axi_rresp_out <= DRS_RESP_OKAY;
      case (s_axi_araddr_in)
        DRS_STATUS_OFS: begin
          s_axi_rdata_out <= {24'h00_0000, status};
        end
        DRS_CONTROL_OFS: begin
          s_axi_rdata_out <= {24'h00_0000, ctrl, 5'h00};
        end
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= DRS_RESP_SLVERR;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== design/drs_pkg.sv ====
package drs_pkg;
  // ==========================================================
  // register map, byte addresses on the AXI4-Lite port
  localparam logic [3:0] DRS_STATUS_OFS = 4'h0;
  localparam logic [3:0] DRS_CONTROL_OFS = 4'h4;
  localparam int DRS_ADDR_W = 4;
  // ==========================================================
  // field positions inside the control byte
  localparam int DRS_CTL_ENABLE_BIT = 7;
  localparam int DRS_CTL_ARM_BIT = 6;
  localparam int DRS_CTL_BEGIN_BIT = 5;
  // ==========================================================
  // capture depth and reset values
  localparam logic [3:0] DRS_FIFO_DEPTH = 4'h8;
  localparam logic [7:0] DRS_STATUS_RESET = 8'h00;
  localparam logic [7:0] DRS_CONTROL_RESET = 8'h00;
  localparam logic [1:0] DRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] DRS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic comparator_a_hit_flag;
    logic comparator_b_hit_flag;
    logic armed_status_flag;
    logic reserved;
    logic [3:0] fifo_valid_count;
  } drs_status_t;

  typedef struct packed {
    logic debug_module_enable;
    logic arm;
    logic begin_trace;
  } drs_ctrl_t;
endpackage

// ==== dv/drs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module drs_checker
  import drs_pkg::*;
(
  // clock, register bus and run state
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [DRS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rready_in,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_awready_out,
  input wire logic armed_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // ====
  // answers hold until taken, and the address channel stays closed meanwhile
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer moved");
  read_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("arready while rvalid");
  write_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
    else $error("awready while bvalid");
  // ====
  // read contents
  zero_bits_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0 && !s_axi_rdata_out[4])
    else $error("reserved bits set");
  count_max_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[3:0] <= 4'h8)
    else $error("count above depth");
  unmapped_a: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 4'h8
    |=> s_axi_rresp_out == DRS_RESP_SLVERR && s_axi_rdata_out == 32'h0) else $error("unmapped read");
  armed_copy_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    && s_axi_araddr_in == DRS_STATUS_OFS |=> s_axi_rdata_out[5] == $past(armed_out))
    else $error("armed bit differs");
endmodule
bind drs_debug_run_status drs_checker u_chk (.clock_in, .srst_in, .s_axi_araddr_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rready_in, .s_axi_rvalid_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_bready_in, .s_axi_bvalid_out, .s_axi_awready_out, .armed_out);
`default_nettype wire

// ==== dv/drs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module drs_host_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // drain request and fifo side
  input wire logic drain_in,
  output logic fifo_read_out,
  output logic [7:0] words_read_out
);
  // ====
  // the device count never drops on reads, so the host tallies words itself
  always_ff @(posedge clock_in) begin
    fifo_read_out <= drain_in && !srst_in;
    if (srst_in) begin
      words_read_out <= 8'h00;
    end else if (drain_in) begin
      words_read_out <= words_read_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== dv/drs_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import drs_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic ca = 1'b0, cb = 1'b0, trig = 1'b0, cap = 1'b0, drain = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrd, bv, arr, rv, store, armed, frd;
  logic [1:0] bresp, rresp;
  logic [7:0] tally;
  int errors = 0;
  int total_checks = 0;
  always #2 clock_in = ~clock_in;
  drs_host_model u_host (.clock_in, .srst_in, .drain_in(drain), .fifo_read_out(frd),
    .words_read_out(tally));
  drs_debug_run_status u_dut (.clock_in, .srst_in, .comp_a_match_in(ca), .comp_b_match_in(cb),
    .trigger_in(trig), .capture_word_in(cap), .fifo_read_in(frd), .capture_store_out(store),
    .armed_out(armed), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hung;
    errors++;
    close_out();
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clock_in);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    if (i == 40) hung();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    // idle edge so a following call never drives bready twice in one step
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clock_in);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    if (i == 40) hung();
    chk("rdata", e, rdat);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    // idle edge so a following call never drives rready twice in one step
    @(posedge clock_in);
  endtask
  task automatic caps(input int n);
    repeat (n) begin
      cap <= 1'b1;
      @(posedge clock_in);
      cap <= 1'b0;
      @(posedge clock_in);
    end
  endtask
  task automatic pulse_trig;
    trig <= 1'b1;
    @(posedge clock_in);
    trig <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  function automatic logic [31:0] st(input logic a, b, m, input logic [3:0] c);
    return {24'h0, a, b, m, 1'b0, c};
  endfunction
  initial begin
    logic ea, eb;
    int n, k;
    n = $urandom(22);
    k = 0;
    repeat (12) @(posedge clock_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rd(DRS_STATUS_OFS, 32'h0, DRS_RESP_OKAY);
    wr(DRS_STATUS_OFS, 8'hFF, DRS_RESP_OKAY);
    rd(DRS_STATUS_OFS, 32'h0, DRS_RESP_OKAY);
    rd(4'h8, 32'h0, DRS_RESP_SLVERR);
    wr(4'hC, 8'h00, DRS_RESP_SLVERR);
    // ====
    // end-trace runs, random hits and word counts, last one past the depth
    repeat (4) begin
      {ea, eb} = 2'($urandom);
      n = k == 3 ? 10 : int'($urandom_range(8));
      wr(DRS_CONTROL_OFS, 8'hC0, DRS_RESP_OKAY);
      rd(DRS_STATUS_OFS, st(0, 0, 1, 0), DRS_RESP_OKAY);
      caps(n);
      ca <= ea;
      cb <= eb;
      @(posedge clock_in);
      ca <= 1'b0;
      cb <= 1'b0;
      drain <= 1'b1;
      repeat (3) @(posedge clock_in);
      drain <= 1'b0;
      k++;
      repeat (2) @(posedge clock_in);
      chk("tally", 32'(3 * k), {24'h0, tally});
      rd(DRS_STATUS_OFS, st(ea, eb, 1, 4'(n > 8 ? 8 : n)), DRS_RESP_OKAY);
      chk("armed", 32'h1, {31'h0, armed});
      pulse_trig();
      rd(DRS_STATUS_OFS, st(ea, eb, 0, 4'(n > 8 ? 8 : n)), DRS_RESP_OKAY);
      chk("armed", 32'h0, {31'h0, armed});
    end
    // ====
    // begin trace: nothing stored before the trigger, run ends when full
    wr(DRS_CONTROL_OFS, 8'hE0, DRS_RESP_OKAY);
    caps(2);
    chk("store", 32'h0, {31'h0, store});
    pulse_trig();
    chk("store", 32'h1, {31'h0, store});
    caps(8);
    repeat (3) @(posedge clock_in);
    rd(DRS_STATUS_OFS, st(0, 0, 0, 8), DRS_RESP_OKAY);
    // ====
    // software ends runs through arm and through enable
    wr(DRS_CONTROL_OFS, 8'hC0, DRS_RESP_OKAY);
    wr(DRS_CONTROL_OFS, 8'h80, DRS_RESP_OKAY);
    rd(DRS_STATUS_OFS, st(0, 0, 0, 0), DRS_RESP_OKAY);
    wr(DRS_CONTROL_OFS, 8'hC0, DRS_RESP_OKAY);
    wr(DRS_CONTROL_OFS, 8'h40, DRS_RESP_OKAY);
    rd(DRS_STATUS_OFS, st(0, 0, 0, 0), DRS_RESP_OKAY);
    close_out();
  end
endmodule
`default_nettype wire
